// File: logic/sgc_ctrl_regs.sv
// Purpose: shared slave address, soft reset and global configuration registers
// Assumes: simple 8-bit register port (addr, wr_en, rd_en, wdata, rdata)
// Notes: rst_n stands for hardware power-down; full soft reset acts like it on the address, override and config registers
// Summary of operation
// RULE1: address field reads current slave address
// RULE2: override set lets software write address
// RULE3: select 0 strap, 1 register address
// RULE4: reload bit restarts rom load, self-clears
// RULE5: software polls init-done after reload
// RULE6: init-done status set after rom load
// RULE7: full soft reset clears logic and registers
// RULE8: logic soft reset keeps register contents
// RULE9: software prefers logic reset to keep configuration
// RULE10: bit5 enables local bus master
// RULE11: policy 0, no lock: transmitter high impedance
// RULE12: policy 1, no lock: transmitter LP-11
// RULE13: sleep select 1, enable 0: high impedance
// RULE14: sleep select 0, no lock: HS-0
// RULE15: bit1 enables receiver parity checking
// RULE16: bit0 forces reference clock present
// RULE17: config resets to 0x1E
`timescale 1ns/1ps
`include "sgc_regs.svh"
module sgc_ctrl_regs import sgc_pkg::*; (
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // synchronous power-down reset, low active
    input wire logic [6:0] strap_addr, // strapped slave address pins
    input wire logic [7:0] addr, // register offset
    input wire logic wr_en, // write strobe, one cycle
    input wire logic rd_en, // read strobe, one cycle
    input wire logic [7:0] wdata, // write data
    output logic [7:0] rdata, // read data, valid cycle after rd_en
    input wire logic [1:0] rx_lock_pin, // lock of receivers assigned to each tx port
    input wire logic ref_clk_det, // reference clock detector result
    output logic [6:0] slave_addr, // slave address in use
    output logic logic_rst_pulse, // digital logic reset pulse
    output logic master_en, // local bus master enable
    output logic parity_chk_en, // receiver parity checker enable
    output logic ref_clk_present, // reported reference clock presence
    output logic init_done, // rom load finished
    output logic [1:0] tx_hiz, // per tx port: drive high impedance
    output logic [1:0] tx_force_lp11, // per tx port: hold LP-11
    output logic [1:0] tx_force_hs0 // per tx port: force HS-0
);
    logic [6:0] addr_reg, addr_next;
    logic ovr_reg, ovr_next;
    logic [7:0] cfg_reg, cfg_next;
    logic [7:0] rdata_reg, rdata_next;
    logic strap_seen_reg, strap_seen_next;
    logic lrst_reg, lrst_next;
    logic reload_reg, reload_next;
    logic [2:0] lock_s0_reg, lock_s1_reg, lock_s2_reg;
    logic [1:0] lock_reg, lock_next;
    logic full_rst_req;
    logic regs_rst_n;
    logic [7:0] status_val;

    // full soft reset returns the address, override and config registers to defaults; rdata and the lock stages keep their values
    // it also restarts the rom load and pulses the logic reset
    assign full_rst_req = wr_en && (addr == `SGC_OFS_SOFT_RST)
        && wdata[`SGC_BIT_FULL_RST]; // [RULE7]
    assign regs_rst_n = rst_n; // the full reset is taken in the next-state logic below

    always_comb begin
        addr_next = addr_reg;
        ovr_next = ovr_reg;
        cfg_next = cfg_reg;
        strap_seen_next = 1'b1;
        lrst_next = 1'b0;
        reload_next = 1'b0;
        // strap caught on the first clock after power-on release
        if (!strap_seen_reg) begin
            addr_next = strap_addr; // [RULE1]
        end
        if (full_rst_req) begin
            ovr_next = 1'b0; // [RULE7]
            cfg_next = `SGC_GLB_CFG_RST;
            addr_next = strap_addr;
            lrst_next = 1'b1;
            reload_next = 1'b1;
        end else if (wr_en) begin
            unique case (addr)
                `SGC_OFS_SLAVE_ADDR: begin
                    ovr_next = wdata[`SGC_BIT_OVR_SEL]; // [RULE3]
                    if (wdata[`SGC_BIT_OVR_SEL]) begin
                        addr_next = wdata[`SGC_ADDR_MSB:`SGC_ADDR_LSB]; // [RULE2]
                    end else begin
                        addr_next = strap_addr; // [RULE3]
                    end
                end
                `SGC_OFS_SOFT_RST: begin
                    lrst_next = wdata[`SGC_BIT_LOGIC_RST]; // [RULE8]
                    reload_next = wdata[`SGC_BIT_RELOAD]; // [RULE4]
                end
                `SGC_OFS_GLB_CFG: begin
                    cfg_next = wdata & `SGC_GLB_CFG_MASK; // reserved bits stay 0
                end
                default: begin
                end
            endcase
        end
    end

    // status carries only the two flags this block owns, the rest reads 0
    always_comb begin
        status_val = `SGC_ZERO8;
        status_val[`SGC_BIT_INIT_DONE] = init_done; // [RULE6]
        status_val[`SGC_BIT_REF_VALID] = ref_clk_present; // [RULE16]
    end

    // rdata keeps its last value between reads, so a slow master can fetch it late
    always_comb begin
        rdata_next = rdata_reg;
        if (rd_en) begin
            unique case (addr)
                `SGC_OFS_SLAVE_ADDR: begin
                    rdata_next[`SGC_ADDR_MSB:`SGC_ADDR_LSB] = addr_reg; // [RULE1]
                    rdata_next[`SGC_BIT_OVR_SEL] = ovr_reg; // [RULE3]
                end
                // self-clearing bits always read back 0
                `SGC_OFS_SOFT_RST: rdata_next = `SGC_ZERO8; // [RULE4] [RULE7] [RULE8]
                `SGC_OFS_GLB_CFG: rdata_next = cfg_reg;
                `SGC_OFS_DEV_STATUS: rdata_next = status_val; // [RULE6]
                default: rdata_next = `SGC_ZERO8;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!regs_rst_n) begin
            addr_reg <= `SGC_ADDR_RST;
            ovr_reg <= 1'b0;
            cfg_reg <= `SGC_GLB_CFG_RST; // [RULE17]
            rdata_reg <= `SGC_ZERO8;
            strap_seen_reg <= 1'b0;
            lrst_reg <= 1'b0;
            reload_reg <= 1'b0;
        end else begin
            addr_reg <= addr_next;
            ovr_reg <= ovr_next;
            cfg_reg <= cfg_next;
            rdata_reg <= rdata_next;
            strap_seen_reg <= strap_seen_next;
            lrst_reg <= lrst_next;
            reload_reg <= reload_next;
        end
    end

    // lock and detector come from other domains: three stages, change when last two agree
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            lock_s0_reg <= 3'h0;
            lock_s1_reg <= 3'h0;
            lock_s2_reg <= 3'h0;
            lock_reg <= 2'h0;
        end else begin
            lock_s0_reg <= {ref_clk_det, rx_lock_pin};
            lock_s1_reg <= lock_s0_reg;
            lock_s2_reg <= lock_s1_reg;
            lock_reg <= lock_next;
        end
    end

    logic refdet_reg, refdet_next;
    always_comb begin
        lock_next = lock_reg;
        refdet_next = refdet_reg;
        if (lock_s1_reg == lock_s2_reg) begin
            lock_next = lock_s2_reg[1:0];
            refdet_next = lock_s2_reg[2];
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            refdet_reg <= 1'b0;
        end else begin
            refdet_reg <= refdet_next;
        end
    end

    // a reload asked for while a load still runs is dropped; the running load
    // still ends with done set, so software polling sees completion either way
    sgc_rom_loader u_loader (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .start(reload_reg), // [RULE4]
        .done(init_done)
    );

    // sleep select 0 wins over the unlock policy: unlocked lanes sit in HS-0
    // whatever the policy bit says; the policy only chooses between off and LP-11
    sgc_tx_state_t tx_state [2];
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_tx
            always_comb begin
                tx_state[gi] = SGC_TX_RUN;
                if (cfg_reg[`SGC_BIT_SLEEP_SEL] && !cfg_reg[`SGC_BIT_OUT_EN]) begin
                    tx_state[gi] = SGC_TX_HIZ; // [RULE13]
                end else if (!lock_reg[gi]) begin
                    if (!cfg_reg[`SGC_BIT_SLEEP_SEL]) begin
                        tx_state[gi] = SGC_TX_HS0; // [RULE14]
                    end else if (!cfg_reg[`SGC_BIT_UNLOCK_POL]) begin
                        tx_state[gi] = SGC_TX_HIZ; // [RULE11]
                    end else begin
                        tx_state[gi] = SGC_TX_LP11; // [RULE12]
                    end
                end
            end
            assign tx_hiz[gi] = (tx_state[gi] == SGC_TX_HIZ);
            assign tx_force_lp11[gi] = (tx_state[gi] == SGC_TX_LP11);
            assign tx_force_hs0[gi] = (tx_state[gi] == SGC_TX_HS0);
        end
    endgenerate

    assign rdata = rdata_reg;
    assign slave_addr = addr_reg;
    assign logic_rst_pulse = lrst_reg; // [RULE8]
    assign master_en = cfg_reg[`SGC_BIT_MST_EN]; // [RULE10]
    assign parity_chk_en = cfg_reg[`SGC_BIT_PAR_EN]; // [RULE15]
    assign ref_clk_present = cfg_reg[`SGC_BIT_REF_FORCE] | refdet_reg; // [RULE16]
endmodule

// File: logic/sgc_regs.svh
// Purpose: offsets, field positions and reset values of the shared control registers
// Assumes: 8-bit register port, byte offsets as printed
// Notes: included by the package-using modules
`ifndef SGC_REGS_SVH
`define SGC_REGS_SVH
`define SGC_OFS_SLAVE_ADDR 8'h00
`define SGC_OFS_SOFT_RST 8'h01
`define SGC_OFS_GLB_CFG 8'h02
`define SGC_OFS_DEV_STATUS 8'h04
`define SGC_BIT_OVR_SEL 0
`define SGC_BIT_RELOAD 2
`define SGC_BIT_FULL_RST 1
`define SGC_BIT_LOGIC_RST 0
`define SGC_BIT_MST_EN 5
`define SGC_BIT_UNLOCK_POL 4
`define SGC_BIT_OUT_EN 3
`define SGC_BIT_SLEEP_SEL 2
`define SGC_BIT_PAR_EN 1
`define SGC_BIT_REF_FORCE 0
`define SGC_BIT_INIT_DONE 6
`define SGC_BIT_REF_VALID 4
`define SGC_GLB_CFG_RST 8'h1E
`define SGC_ZERO8 8'h00
`define SGC_ROM_LOAD_CYC 8'h40
`define SGC_ADDR_MSB 7
`define SGC_ADDR_LSB 1
`define SGC_ADDR_RST 7'h00
`define SGC_GLB_CFG_MASK 8'h3F
`endif

// File: logic/sgc_pkg.sv
// Purpose: shared types of the shared control register block
// Assumes: nothing
// Notes: offsets and values live in sgc_regs.svh
package sgc_pkg;
    typedef enum logic [1:0] {
        SGC_TX_RUN,
        SGC_TX_LP11,
        SGC_TX_HS0,
        SGC_TX_HIZ
    } sgc_tx_state_t;
endpackage

// File: logic/sgc_rom_loader.sv
// Purpose: sequences the configuration rom auto-load after reset or restart
// Assumes: rom read lasts a fixed count of cycles
// Notes: done stays high until the next load starts
`timescale 1ns/1ps
`include "sgc_regs.svh"
module sgc_rom_loader import sgc_pkg::*; (
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // synchronous reset, low active
    input wire logic start, // one-cycle load request
    output logic done // load finished
);
    typedef enum logic {SGC_LD_BUSY, SGC_LD_IDLE} sgc_ld_state_t;
    sgc_ld_state_t state_reg, state_next;
    logic [7:0] cnt_reg, cnt_next;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        unique case (state_reg)
            SGC_LD_BUSY: begin
                if (cnt_reg == `SGC_ROM_LOAD_CYC) begin
                    state_next = SGC_LD_IDLE;
                end else begin
                    cnt_next = cnt_reg + 8'h01;
                end
            end
            SGC_LD_IDLE: begin
                if (start) begin
                    state_next = SGC_LD_BUSY;
                    cnt_next = `SGC_ZERO8;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_reg <= SGC_LD_BUSY;
            cnt_reg <= `SGC_ZERO8;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    assign done = (state_reg == SGC_LD_IDLE); // [RULE6]
endmodule

// File: sim/sgc_ctrl_regs_asserts.sv
// Purpose: port checks of the shared control registers
// Assumes: one clock, synchronous low-active reset
// Notes: bound after the module
`timescale 1ns/1ps
module sgc_ctrl_regs_asserts (
    input wire logic clk_sys, // clock
    input wire logic rst_n, // reset
    input wire logic [6:0] strap_addr, // strap
    input wire logic [7:0] addr, // offset
    input wire logic wr_en, // write
    input wire logic [7:0] wdata, // data
    input wire logic [6:0] slave_addr, // address used
    input wire logic logic_rst_pulse, // logic reset
    input wire logic master_en, // master on
    input wire logic parity_chk_en, // parity on
    input wire logic ref_clk_present, // ref clock
    input wire logic init_done // rom loaded
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic cfg_wr;
    logic rst_wr;
    assign cfg_wr = wr_en && addr == 8'h02;
    assign rst_wr = wr_en && addr == 8'h01;
    a_master_follow: assert property (cfg_wr |=> master_en == $past(wdata[5]))
        else $error("master enable wrong");
    a_parity_follow: assert property (cfg_wr |=> parity_chk_en == $past(wdata[1]))
        else $error("parity enable wrong");
    a_ref_forced: assert property (cfg_wr && wdata[0] |=> ref_clk_present)
        else $error("ref clock not forced");
    a_rst_pulse_cause: assert property (rst_wr && wdata[0] |=> logic_rst_pulse)
        else $error("no logic reset pulse");
    a_rst_pulse_width: assert property (logic_rst_pulse |=> !logic_rst_pulse)
        else $error("reset pulse too long");
    a_reload_drop: assert property (rst_wr && wdata[2] |-> ##[1:3] !init_done)
        else $error("reload not started");
    a_addr_override: assert property (wr_en && addr == 8'h00 && wdata[0]
        |=> slave_addr == $past(wdata[7:1]))
        else $error("override address not used");
    a_addr_strap: assert property (wr_en && addr == 8'h00 && !wdata[0]
        |=> slave_addr == strap_addr)
        else $error("strap address not used");
endmodule
bind sgc_ctrl_regs sgc_ctrl_regs_asserts u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .strap_addr(strap_addr), .addr(addr), .wr_en(wr_en), .wdata(wdata),
    .slave_addr(slave_addr), .logic_rst_pulse(logic_rst_pulse), .master_en(master_en),
    .parity_chk_en(parity_chk_en), .ref_clk_present(ref_clk_present), .init_done(init_done));

// File: sim/tb_shared_global_control_regs.sv
// Purpose: self-checking bench of the shared control registers
// Assumes: reads answer one cycle after rd_en
// Notes: expected read values go through a queue to the monitor
`timescale 1ns/1ps
module tb_shared_global_control_regs;
    logic clk_sys, rst_n, wr_en, rd_en, ref_clk_det, rd_q;
    logic [6:0] strap_addr, slave_addr, new_addr;
    logic [7:0] addr, wdata, rdata, d;
    logic [1:0] rx_lock_pin, tx_hiz, tx_force_lp11, tx_force_hs0;
    logic logic_rst_pulse, master_en, parity_chk_en, ref_clk_present, init_done;
    logic [7:0] exp_q[$];
    logic [15:0] tab [5];
    int bad_count, total_checks, cyc, i, seed;
    sgc_ctrl_regs DUT (.clk_sys(clk_sys), .rst_n(rst_n), .strap_addr(strap_addr),
        .addr(addr), .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata), .rdata(rdata),
        .rx_lock_pin(rx_lock_pin), .ref_clk_det(ref_clk_det), .slave_addr(slave_addr),
        .logic_rst_pulse(logic_rst_pulse), .master_en(master_en),
        .parity_chk_en(parity_chk_en), .ref_clk_present(ref_clk_present),
        .init_done(init_done), .tx_hiz(tx_hiz), .tx_force_lp11(tx_force_lp11),
        .tx_force_hs0(tx_force_hs0));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        addr <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        addr <= a;
        rd_en <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_sys);
        rd_en <= 1'b0;
    endtask
    task automatic wait_init();
        int n;
        for (n = 0; n < 200 && init_done !== 1'b1; n++) @(posedge clk_sys);
        chk({7'h0, init_done}, 8'h01);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        rd_q <= rd_en;
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            stop_test();
        end
    end
    // read data settles after the edge, so compare mid-cycle
    always @(negedge clk_sys) if (rd_q === 1'b1) chk(rdata, exp_q.pop_front());
    initial begin
        seed = 98;
        rst_n = 1'b0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        rx_lock_pin = 2'b00;
        ref_clk_det = 1'b0;
        strap_addr = 7'($random(seed));
        tab = '{{2'b00, 8'h04, 6'b110000}, {2'b00, 8'h00, 6'b000011},
            {2'b00, 8'h0C, 6'b110000}, {2'b00, 8'h1C, 6'b001100}, {2'b01, 8'h0C, 6'b100000}};
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rd(8'h00, {strap_addr, 1'b0});
        rd(8'h02, 8'h1E);
        rd(8'h07, 8'h00);
        wait_init();
        rd(8'h04, 8'h40);
        wr(8'h00, 8'hAA);
        rd(8'h00, {strap_addr, 1'b0});
        new_addr = 7'($random(seed));
        wr(8'h00, {new_addr, 1'b1});
        rd(8'h00, {new_addr, 1'b1});
        chk({1'b0, slave_addr}, {1'b0, new_addr});
        wr(8'h00, 8'h00);
        @(negedge clk_sys);
        chk({1'b0, slave_addr}, {1'b0, strap_addr});
        for (i = 0; i < 4; i++) begin
            d = 8'($random(seed));
            d[0] = i[0]; // both settings of the forced reference flag are seen
            wr(8'h02, d);
            @(negedge clk_sys);
            chk({5'h0, master_en, parity_chk_en, ref_clk_present},
                {5'h0, d[5], d[1], d[0]});
            rd(8'h02, d & 8'h3F);
        end
        wr(8'h02, 8'h1E);
        ref_clk_det <= 1'b1;
        repeat (8) @(posedge clk_sys);
        rd(8'h04, 8'h50);
        ref_clk_det <= 1'b0;
        for (i = 0; i < 5; i++) begin
            rx_lock_pin <= tab[i][15:14];
            wr(8'h02, tab[i][13:6]);
            repeat (6) @(negedge clk_sys);
            chk({2'b00, tx_hiz, tx_force_lp11, tx_force_hs0},
                {2'b00, tab[i][5:0]});
        end
        wr(8'h01, 8'h04);
        repeat (3) @(posedge clk_sys);
        chk({7'h0, init_done}, 8'h00);
        wait_init();
        rd(8'h01, 8'h00);
        wr(8'h02, 8'h3F);
        wr(8'h01, 8'h01);
        @(negedge clk_sys);
        chk({7'h0, logic_rst_pulse}, 8'h01);
        rd(8'h02, 8'h3F);
        wr(8'h00, {new_addr, 1'b1});
        wr(8'h01, 8'h02);
        repeat (4) @(posedge clk_sys);
        wait_init();
        rd(8'h02, 8'h1E);
        rd(8'h00, {strap_addr, 1'b0});
        repeat (2) @(posedge clk_sys);
        stop_test();
    end
endmodule
